/* File: src/lsu_pkg.sv */
// Package with the operation codes, structs and constants of the load/store address unit.
package lsu_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_IDX_W = 4;
    localparam int unsigned FLAGS_W = 4;
    localparam logic [REG_IDX_W-1:0] SP_IDX = 4'hD;
    localparam logic [REG_IDX_W-1:0] PC_IDX = 4'hF;
    localparam logic [DATA_W-1:0] PC_AHEAD = 32'h0000_0004;
    localparam logic [DATA_W-1:0] PAIR_STEP = 32'h0000_0004;
    localparam logic [DATA_W-1:0] WORD_ALIGN_MASK = 32'hFFFF_FFFD;
    localparam logic [DATA_W-1:0] HALF_ALIGN_MASK = 32'hFFFF_FFFE;
    localparam int BYTE_W = 8;
    localparam int HALF_W = 16;
    localparam int OFS_W = 13;
    localparam logic signed [OFS_W-1:0] OFS_MAX_OFFSET = 13'sh0FFF;
    localparam logic signed [OFS_W-1:0] OFS_MAX_INDEXED = 13'sh00FF;
    localparam logic signed [OFS_W-1:0] OFS_MIN_SINGLE = -13'sh00FF;
    localparam logic signed [OFS_W-1:0] OFS_MAX_PAIR = 13'sh03FC;
    localparam logic signed [OFS_W-1:0] OFS_MIN_PAIR = -13'sh03FC;
    localparam logic signed [OFS_W-1:0] OFS_MAX_PCREL = 13'sh0FFF;

    typedef enum logic [2:0] {
        OP_ADDR_GEN = 3'h0,
        OP_LOAD = 3'h1,
        OP_STORE = 3'h2,
        OP_LOAD_PAIR = 3'h3,
        OP_STORE_PAIR = 3'h4
    } op_e;

    typedef enum logic [2:0] {
        SZ_BYTE = 3'h0,
        SZ_SIGNED_BYTE = 3'h1,
        SZ_HALF = 3'h2,
        SZ_SIGNED_HALF = 3'h3,
        SZ_WORD = 3'h4
    } size_e;

    typedef enum logic [1:0] {
        MODE_OFFSET = 2'h0,
        MODE_PRE = 2'h1,
        MODE_POST = 2'h2
    } mode_e;

    typedef struct packed {
        op_e op;
        size_e size;
        mode_e mode;
        logic cond_pass;
        logic signed [OFS_W-1:0] offset;
        logic [REG_IDX_W-1:0] base_register;
        logic [REG_IDX_W-1:0] transfer_register;
        logic [REG_IDX_W-1:0] second_transfer_register;
        logic [DATA_W-1:0] instr_addr;
        logic [DATA_W-1:0] base_value;
        logic [DATA_W-1:0] store_value;
        logic [DATA_W-1:0] store_value2;
    } instr_s;

    typedef struct packed {
        logic req;
        logic write;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] byte_en;
    } mem_req_s;

    typedef struct packed {
        logic en;
        logic [REG_IDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
    } reg_wr_s;

endpackage

/* File: src/load_store_address_unit.sv */
// Load/store address unit: address generation, memory sequencing and register writeback.
`timescale 1ns/1ps
module load_store_address_unit
    import lsu_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input instr_s instr,
    output logic instr_ready,
    output mem_req_s mem_req,
    input wire logic mem_ack,
    input wire logic [DATA_W-1:0] mem_rdata,
    output reg_wr_s reg_wr,
    output logic branch_valid,
    output logic [DATA_W-1:0] branch_target,
    output logic offset_fault,
    input wire logic [FLAGS_W-1:0] flags_in,
    output logic [FLAGS_W-1:0] flags_out
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic [DATA_W-1:0] add_ofs(input logic [DATA_W-1:0] b, input logic signed [OFS_W-1:0] o);
        return b + DATA_W'(o);
    endfunction

    function automatic logic [3:0] lane_en(input size_e s, input logic [1:0] a);
        unique case (s)
            SZ_BYTE, SZ_SIGNED_BYTE: lane_en = 4'h1 << a;
            SZ_HALF, SZ_SIGNED_HALF: lane_en = a[1] ? 4'hC : 4'h3;
            default: lane_en = 4'hF;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] extend(input size_e s, input logic [DATA_W-1:0] d, input logic [1:0] a);
        logic [BYTE_W-1:0] b;
        logic [HALF_W-1:0] h;
        b = d[a*BYTE_W +: BYTE_W];
        h = a[1] ? d[DATA_W-1 -: HALF_W] : d[HALF_W-1:0];
        unique case (s)
            SZ_BYTE: extend = {{(DATA_W-BYTE_W){1'b0}}, b};
            SZ_SIGNED_BYTE: extend = {{(DATA_W-BYTE_W){b[BYTE_W-1]}}, b};
            SZ_HALF: extend = {{(DATA_W-HALF_W){1'b0}}, h};
            SZ_SIGNED_HALF: extend = {{(DATA_W-HALF_W){h[HALF_W-1]}}, h};
            default: extend = d;
        endcase
    endfunction

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FIRST = 4'b0010,
        ST_SECOND = 4'b0100,
        ST_WBACK = 4'b1000
    } state_e;

    state_e state_q, state_d;
    instr_s ins_q, ins_d;
    logic [DATA_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wb_q, wb_d;
    logic instr_ready_d, branch_valid_d, offset_fault_d;
    logic [DATA_W-1:0] branch_target_d;
    mem_req_s mem_req_d;
    reg_wr_s reg_wr_d;
    logic pair, is_load, ofs_ok, mode_ok;
    logic [DATA_W-1:0] sum, pc_val, ld_val;

    always_comb begin
        pair = instr.op inside {OP_LOAD_PAIR, OP_STORE_PAIR};
        sum = add_ofs(instr.base_value, instr.offset);
        pc_val = (instr.instr_addr + PC_AHEAD) & WORD_ALIGN_MASK;
        mode_ok = instr.mode != MODE_POST || instr.op != OP_ADDR_GEN;
        if (instr.op == OP_ADDR_GEN) begin
            ofs_ok = instr.offset <= OFS_MAX_PCREL && instr.offset >= -OFS_MAX_PCREL;
        end else if (pair) begin
            ofs_ok = instr.offset[1:0] == 2'h0 && instr.offset <= OFS_MAX_PAIR
                && instr.offset >= OFS_MIN_PAIR;
        end else if (instr.mode == MODE_OFFSET) begin
            ofs_ok = instr.offset <= OFS_MAX_OFFSET && instr.offset >= OFS_MIN_SINGLE;
        end else begin
            ofs_ok = instr.offset <= OFS_MAX_INDEXED && instr.offset >= OFS_MIN_SINGLE;
        end
        is_load = ins_q.op inside {OP_LOAD, OP_LOAD_PAIR};
        ld_val = extend(ins_q.size, mem_rdata, addr_q[1:0]);
    end

    always_comb begin
        state_d = state_q;
        ins_d = ins_q;
        addr_d = addr_q;
        wb_d = wb_q;
        instr_ready_d = 1'b0;
        branch_valid_d = 1'b0;
        branch_target_d = branch_target;
        offset_fault_d = 1'b0;
        mem_req_d = mem_req;
        reg_wr_d = '0;
        unique case (state_q)
            ST_IDLE: begin
                if (instr_valid) begin
                    instr_ready_d = 1'b1;
                    ins_d = instr;
                    if (!instr.cond_pass) begin
                        state_d = ST_IDLE;
                    end else if (!ofs_ok || !mode_ok) begin
                        offset_fault_d = 1'b1;
                    end else if (instr.op == OP_ADDR_GEN) begin
                        reg_wr_d = '{en: 1'b1, idx: instr.transfer_register,
                                     data: add_ofs(pc_val, instr.offset)};
                    end else begin
                        addr_d = (instr.mode == MODE_POST) ? instr.base_value : sum;
                        wb_d = sum;
                        mem_req_d.req = 1'b1;
                        mem_req_d.write = instr.op inside {OP_STORE, OP_STORE_PAIR};
                        mem_req_d.addr = (instr.mode == MODE_POST) ? instr.base_value : sum;
                        mem_req_d.wdata = instr.store_value;
                        mem_req_d.byte_en = pair ? 4'hF : lane_en(instr.size,
                            instr.mode == MODE_POST ? instr.base_value[1:0] : sum[1:0]);
                        state_d = ST_FIRST;
                    end
                end
            end
            ST_FIRST: begin
                if (mem_ack) begin
                    mem_req_d.req = 1'b0;
                    if (is_load && ins_q.transfer_register == PC_IDX && ins_q.size == SZ_WORD
                        && ins_q.op == OP_LOAD) begin
                        branch_valid_d = 1'b1;
                        branch_target_d = mem_rdata & HALF_ALIGN_MASK;
                    end else if (is_load) begin
                        // A pair always moves whole words, whatever the size field carries.
                        reg_wr_d = '{en: 1'b1, idx: ins_q.transfer_register,
                                     data: (ins_q.op == OP_LOAD_PAIR) ? mem_rdata : ld_val};
                    end
                    if (ins_q.op inside {OP_LOAD_PAIR, OP_STORE_PAIR}) begin
                        addr_d = addr_q + PAIR_STEP;
                        mem_req_d.req = 1'b1;
                        mem_req_d.addr = addr_q + PAIR_STEP;
                        mem_req_d.wdata = ins_q.store_value2;
                        state_d = ST_SECOND;
                    end else begin
                        state_d = ST_WBACK;
                    end
                end
            end
            ST_SECOND: begin
                if (mem_ack) begin
                    mem_req_d.req = 1'b0;
                    if (is_load) begin
                        reg_wr_d = '{en: 1'b1, idx: ins_q.second_transfer_register, data: mem_rdata};
                    end
                    state_d = ST_WBACK;
                end
            end
            ST_WBACK: begin
                if (ins_q.mode != MODE_OFFSET) begin
                    reg_wr_d = '{en: 1'b1, idx: ins_q.base_register, data: wb_q};
                end
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            ins_q <= '0;
            addr_q <= '0;
            wb_q <= '0;
            instr_ready <= 1'b0;
            branch_valid <= 1'b0;
            branch_target <= '0;
            offset_fault <= 1'b0;
            mem_req <= '0;
            reg_wr <= '0;
            flags_out <= '0;
        end else begin
            state_q <= state_d;
            ins_q <= ins_d;
            addr_q <= addr_d;
            wb_q <= wb_d;
            instr_ready <= instr_ready_d;
            branch_valid <= branch_valid_d;
            branch_target <= branch_target_d;
            offset_fault <= offset_fault_d;
            mem_req <= mem_req_d;
            reg_wr <= reg_wr_d;
            // No operation of this unit alters the condition flags, so they pass through.
            flags_out <= flags_in;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    flags_pass_a: assert property (@(posedge clk) disable iff (!arst_n) ##1 flags_out == $past(flags_in))
        else $error("flags changed");
    cond_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_IDLE && instr_valid && !instr.cond_pass |=> !reg_wr.en && !mem_req.req)
        else $error("failed condition had an effect");
    adr_result_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_IDLE && instr_valid && instr.cond_pass && ofs_ok && instr.op == OP_ADDR_GEN
        && instr.mode != MODE_POST |=> reg_wr.en && reg_wr.idx == $past(instr.transfer_register)
        && reg_wr.data == (($past(instr.instr_addr) + PC_AHEAD) & WORD_ALIGN_MASK) + DATA_W'($past(instr.offset)))
        else $error("address generate result wrong");
    post_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_IDLE && instr_valid && instr.cond_pass && ofs_ok && instr.op != OP_ADDR_GEN
        && instr.mode == MODE_POST |=> mem_req.req && mem_req.addr == $past(instr.base_value))
        else $error("post-index address wrong");
    pre_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_IDLE && instr_valid && instr.cond_pass && ofs_ok && instr.op != OP_ADDR_GEN
        && instr.mode != MODE_POST |=> mem_req.addr == $past(instr.base_value) + DATA_W'($past(instr.offset)))
        else $error("offset address wrong");
    pair_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_FIRST && mem_ack && ins_q.op inside {OP_LOAD_PAIR, OP_STORE_PAIR}
        |=> mem_req.addr == $past(addr_q) + PAIR_STEP)
        else $error("second word address wrong");
    pc_branch_a: assert property (@(posedge clk) disable iff (!arst_n)
        branch_valid |-> branch_target == {$past(mem_rdata[DATA_W-1:1]), 1'b0})
        else $error("branch target wrong");
    range_fault_a: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_IDLE && instr_valid && instr.cond_pass && pair && instr.offset[1:0] != 2'h0
        |=> offset_fault && !mem_req.req)
        else $error("unaligned pair offset accepted");

endmodule

/* File: sim/mem_model.sv */
// Behavioural data memory on the far side of the load/store address unit.
`timescale 1ns/1ps
module mem_model
    import lsu_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input mem_req_s mem_req,
    output logic mem_ack,
    output logic [DATA_W-1:0] mem_rdata
);
    logic [DATA_W-1:0] mem_q [64];
    logic [2:0] wait_q;
    logic [DATA_W-1:0] lane;
    assign lane = mem_req.wdata << {mem_req.addr[1:0], 3'b000};
    // *****************************************************
    // Answer path
    // *****************************************************
    // The read bus toggles between answers so that a stale word never passes for load data.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_ack <= 1'b0;
            wait_q <= 3'h0;
            mem_rdata <= 32'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.req === 1'b1 && !mem_ack && (!slow || wait_q == 3'h3)) begin
                mem_ack <= 1'b1;
                wait_q <= 3'h0;
                mem_rdata <= mem_q[mem_req.addr[7:2]];
                for (int b = 0; b < 4; b++) begin
                    if (mem_req.write && mem_req.byte_en[b]) mem_q[mem_req.addr[7:2]][8*b +: 8] <= lane[8*b +: 8];
                end
            end else if (mem_req.req === 1'b1 && !mem_ack) begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule

/* File: sim/load_store_address_unit_tb.sv */
// Self-checking testbench for the load/store address unit.
`timescale 1ns/1ps
module load_store_address_unit_tb;
    import lsu_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic slow = 1'b0;
    logic clr = 1'b0;
    instr_s instr = '0;
    logic [FLAGS_W-1:0] flags_in = 4'h0;
    logic [FLAGS_W-1:0] flags_out;
    logic instr_ready, mem_ack, branch_valid, offset_fault;
    mem_req_s mem_req;
    reg_wr_s reg_wr;
    logic [DATA_W-1:0] mem_rdata, branch_target;
    int err_total = 0;
    int num_checks = 0;
    int n_wr, n_acc, n_br, n_flt;
    logic [3:0] wr_idx [4];
    logic [31:0] wr_dat [4];
    logic [31:0] acc_addr [4];
    load_store_address_unit dut(.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_wr(reg_wr),
        .branch_valid(branch_valid), .branch_target(branch_target), .offset_fault(offset_fault),
        .flags_in(flags_in), .flags_out(flags_out));
    mem_model mem(.clk(clk), .arst_n(arst_n), .slow(slow), .mem_req(mem_req), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    initial begin
        forever #5 clk = ~clk;
    end
    // The counters have this one driver; a scenario clears them through clr so no update is lost in a race.
    always @(posedge clk) begin
        if (clr) begin
            n_wr <= 0;
            n_acc <= 0;
            n_br <= 0;
            n_flt <= 0;
        end else begin
            if (reg_wr.en === 1'b1) begin
                wr_idx[n_wr % 4] <= reg_wr.idx;
                wr_dat[n_wr % 4] <= reg_wr.data;
                n_wr <= n_wr + 1;
            end
            if (mem_req.req === 1'b1 && mem_ack === 1'b1) begin
                acc_addr[n_acc % 4] <= mem_req.addr;
                n_acc <= n_acc + 1;
            end
            if (branch_valid === 1'b1) n_br <= n_br + 1;
            if (offset_fault === 1'b1) n_flt <= n_flt + 1;
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Base register 7 never overlaps transfer registers, destination is never the stack, and is the counter only in the branch scenario.
    function automatic instr_s mk(op_e op, size_e sz, mode_e m, int ofs, logic [3:0] rt, logic [31:0] base);
        return '{op, sz, m, 1'b1, OFS_W'(ofs), 4'h7, rt, rt + 4'h1, 32'h0000_0100, base, 32'hCAFE_1234,
            32'h5566_7788};
    endfunction
    // The instruction is offered for one cycle only, since the unit is idle whenever a scenario starts.
    task automatic run(input instr_s i);
        int n = 0;
        int quiet = 0;
        int rdy = 0;
        @(posedge clk);
        clr <= 1'b1;
        instr <= i;
        instr_valid <= 1'b1;
        flags_in <= flags_in + 4'h5;
        @(posedge clk);
        instr_valid <= 1'b0;
        clr <= 1'b0;
        while (quiet < 8) begin
            @(negedge clk);
            n++;
            rdy += int'(instr_ready === 1'b1);
            quiet = (mem_req.req === 1'b1 || instr_ready === 1'b1) ? 0 : quiet + 1;
            if (n > 200) begin
                err_total++;
                conclude();
            end
        end
        check("ready", 1, rdy);
        check("flags", 32'(flags_in), 32'(flags_out));
    endtask
    // *****************************************************
    // Scenarios
    // *****************************************************
    task automatic t_addr_gen();
        instr_s i;
        int ofs [2] = '{4095, -4095};
        for (int k = 0; k < 2; k++) begin
            i = mk(OP_ADDR_GEN, SZ_WORD, MODE_OFFSET, ofs[k], 4'h3, 32'h0);
            i.instr_addr = 32'h0000_0106;
            run(i);
            check("adr_idx", 3, wr_idx[0]);
            check("adr_sum", 32'h0000_0108 + 32'(ofs[k]), wr_dat[0]);
        end
        $display("test addr_gen done");
    endtask
    task automatic t_modes();
        mode_e md [4] = '{MODE_OFFSET, MODE_PRE, MODE_POST, MODE_OFFSET};
        int ofs [4] = '{8, -4, 12, 0};
        logic [31:0] a;
        for (int k = 0; k < 4; k++) begin
            a = (md[k] == MODE_POST) ? 32'h50 : 32'h50 + 32'(ofs[k]);
            run(mk(OP_LOAD, SZ_WORD, md[k], ofs[k], 4'h1, 32'h50));
            check("acc_addr", a, acc_addr[0]);
            check("load_data", mem.mem_q[a[7:2]], wr_dat[0]);
            check("wr_count", (md[k] == MODE_OFFSET) ? 1 : 2, n_wr);
            if (md[k] != MODE_OFFSET) check("wb_value", 32'h50 + 32'(ofs[k]), wr_dat[1]);
            if (md[k] != MODE_OFFSET) check("wb_idx", 7, wr_idx[1]);
        end
        $display("test modes done");
    endtask
    task automatic t_ext();
        size_e sz [8] = '{SZ_BYTE, SZ_SIGNED_BYTE, SZ_BYTE, SZ_SIGNED_BYTE, SZ_SIGNED_HALF, SZ_HALF,
            SZ_SIGNED_HALF, SZ_WORD};
        int ofs [8] = '{4, 5, 5, 6, 6, 6, 4, 4};
        logic [31:0] ex [8] = '{32'h1, 32'hFFFF_FFF6, 32'hF6, 32'h7F, 32'hFFFF_807F, 32'h807F, 32'hFFFF_F601,
            32'h807F_F601};
        mem.mem_q[1] = 32'h807F_F601;
        mem.mem_q[2] = 32'h0;
        mem.mem_q[3] = 32'h0;
        for (int k = 0; k < 8; k++) begin
            run(mk(OP_LOAD, sz[k], MODE_OFFSET, ofs[k], 4'h1, 32'h0));
            check("extend", ex[k], wr_dat[0]);
        end
        run(mk(OP_STORE, SZ_BYTE, MODE_OFFSET, 9, 4'h1, 32'h0));
        run(mk(OP_STORE, SZ_HALF, MODE_OFFSET, 14, 4'h1, 32'h0));
        check("store_byte", 32'h0000_3400, mem.mem_q[2]);
        check("store_half", 32'h1234_0000, mem.mem_q[3]);
        $display("test extend done");
    endtask
    task automatic t_range();
        op_e op [9] = '{OP_LOAD, OP_LOAD, OP_LOAD, OP_LOAD_PAIR, OP_LOAD_PAIR, OP_LOAD_PAIR, OP_LOAD, OP_STORE_PAIR,
            OP_ADDR_GEN};
        mode_e md [9] = '{MODE_OFFSET, MODE_OFFSET, MODE_PRE, MODE_OFFSET, MODE_POST, MODE_PRE, MODE_POST, MODE_PRE,
            MODE_POST};
        int ofs [9] = '{4095, -256, 256, 1020, -1024, 6, -255, -1020, 0};
        int bad [9] = '{0, 1, 1, 0, 1, 1, 0, 0, 1};
        int nacc [9] = '{1, 0, 0, 2, 0, 0, 1, 2, 0};
        for (int k = 0; k < 9; k++) begin
            run(mk(op[k], SZ_WORD, md[k], ofs[k], 4'h1, 32'h0));
            check("fault", bad[k], n_flt);
            check("accesses", nacc[k], n_acc);
        end
        $display("test range done");
    endtask
    task automatic t_pair();
        @(posedge clk);
        slow <= 1'b1;
        run(mk(OP_LOAD_PAIR, SZ_WORD, MODE_PRE, -8, 4'h1, 32'h40));
        check("pair_addr1", 32'h3C, acc_addr[1]);
        check("pair_idx1", 2, wr_idx[1]);
        check("pair_data1", mem.mem_q[15], wr_dat[1]);
        check("pair_wb", 32'h38, wr_dat[2]);
        run(mk(OP_STORE_PAIR, SZ_WORD, MODE_POST, 16, 4'h1, 32'h60));
        check("pair_st0", 32'hCAFE_1234, mem.mem_q[24]);
        check("pair_st1", 32'h5566_7788, mem.mem_q[25]);
        check("pair_wb_post", 32'h70, wr_dat[0]);
        slow <= 1'b0;
        $display("test pair done");
    endtask
    task automatic t_branch_skip();
        instr_s i = mk(OP_STORE, SZ_WORD, MODE_PRE, 4, 4'h1, 32'h20);
        mem.mem_q[5] = 32'h0000_2001;
        run(mk(OP_LOAD, SZ_WORD, MODE_OFFSET, 4, PC_IDX, 32'h10));
        check("branch_target", 32'h0000_2000, branch_target);
        check("branch_writes", 0, n_wr);
        check("branch_count", 1, n_br);
        i.cond_pass = 1'b0;
        run(i);
        check("skip_store", 0, n_acc + n_wr);
        i.op = OP_ADDR_GEN;
        i.mode = MODE_OFFSET;
        run(i);
        check("skip_adr", 0, n_wr + n_flt);
        $display("test branch_skip done");
    endtask
    initial begin
        for (int k = 0; k < 64; k++) begin
            mem.mem_q[k] = 32'h1357_0000 + 32'(k * 7);
        end
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_addr_gen();
        t_modes();
        t_ext();
        t_range();
        t_pair();
        t_branch_skip();
        conclude();
    end
endmodule
